/* File: src/ddr2_cmd_ocd_odt_core.sv */
`default_nettype none
// Notes on behaviour
// - drive-high: data, strobes high, complements low
// - calibration field 000/001/010/100/111 decoded
// - beats three/two pull-up, one/zero pull-down
// - one strength setting for all data lines
// - sixteen-step saturating counters, reset step 8
// - code sampled at write latency, fixed order
// - outputs switch one enable delay after command
// - termination follows control pin, off in self-refresh
// - precharge decode closes an open bank
// - auto-precharge bit all banks, else bank pair
// - deselect and nop let work continue
// - activate decode opens one of four banks
// - read decode after activate, mode-register latency
// - write decode after activate, mode-register burst
// - column commands held for additive latency
// - extended register one write captures address pins
module ddr2_cmd_ocd_odt_core
    import ddr2_core_pkg::*;
(
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rstn,
    // command pins, sampled on link clock rises; termination and self-refresh pins every ref_clk cycle
    input  wire logic                  ck,
    input  wire cmd_pins_t             cmd_pins,
    input  wire logic                  termination_ctrl,
    input  wire logic                  self_refresh,
    // data pins
    input  wire logic [DQ_W-1:0]       dq_in,
    output logic      [DQ_W-1:0]       dq_out,
    output logic      [DQ_W-1:0]       dq_oe,
    output logic      [DQS_W-1:0]      dqs_out,
    output logic      [DQS_W-1:0]      dqs_n_out,
    output logic      [DQS_W-1:0]      dqs_oe,
    // termination per line
    output logic      [TERM_LINES-1:0] term_en,
    // driver calibration state
    output cal_mode_t                  cal_mode,
    output logic      [3:0]            pullup_step,
    output logic      [3:0]            pulldown_step,
    // bank and column state
    output logic      [BANKS-1:0]      bank_open,
    output col_cmd_t                   col_launch,
    output logic      [2:0]            burst_length,
    output logic      [2:0]            additive_latency,
    output logic      [3:0]            read_latency,
    output logic      [3:0]            write_latency
);

    // ------------------------------------------------------------
    // reset release and input synchronisers
    // ------------------------------------------------------------
    logic [1:0]      rst_pipe;
    logic            rst_n;
    logic            ck_meta, ck_sync, ck_prev;
    cmd_pins_t       pins_meta, pins;
    logic            term_meta, term_sync, sr_meta, sr_sync;
    logic [DQ_W-1:0] dq_meta, dq_sync;
    logic            ck_rise, ck_fall;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ck_meta   <= 1'b0;
            ck_sync   <= 1'b0;
            ck_prev   <= 1'b0;
            pins_meta <= '1;
            pins      <= '1;
            term_meta <= 1'b0;
            term_sync <= 1'b0;
            sr_meta   <= 1'b0;
            sr_sync   <= 1'b0;
            dq_meta   <= '0;
            dq_sync   <= '0;
        end else begin
            ck_meta   <= ck;
            ck_sync   <= ck_meta;
            ck_prev   <= ck_sync;
            pins_meta <= cmd_pins;
            pins      <= pins_meta;
            term_meta <= termination_ctrl;
            term_sync <= term_meta;
            sr_meta   <= self_refresh;
            sr_sync   <= sr_meta;
            dq_meta   <= dq_in;
            dq_sync   <= dq_meta;
        end
    end
    assign ck_rise = ck_sync & ~ck_prev;
    assign ck_fall = ~ck_sync & ck_prev;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    cmd_t       cmd;
    logic [1:0] bank_idx;
    logic [2:0] cal_field;

    always_comb begin
        cmd = CMD_NONE;
        if (ck_rise && !pins.cs_n) begin
            case ({pins.ras_n, pins.cas_n, pins.we_n})
                3'b011:  cmd = CMD_ACT;
                3'b010:  cmd = CMD_PRE;
                3'b101:  cmd = CMD_READ;
                3'b100:  cmd = CMD_WRITE;
                3'b000:  begin
                    if (!pins.bank_sel_hi && pins.bank_sel_lo) begin
                        cmd = CMD_EMRS1;
                    end else if (!pins.bank_sel_hi && !pins.bank_sel_lo) begin
                        cmd = CMD_MRS;
                    end else begin
                        cmd = CMD_OTHER;
                    end
                end
                3'b111:  cmd = CMD_NONE;
                default: cmd = CMD_OTHER;
            endcase
        end
    end
    // bank pair maps 00 A, 10 B, 01 C, 11 D
    assign bank_idx  = {pins.bank_sel_lo, pins.bank_sel_hi};
    assign cal_field = pins.addr[CAL_HI:CAL_LO];

    // ------------------------------------------------------------
    // mode registers and latencies
    // ------------------------------------------------------------
    logic [2:0] column_latency;
    logic       odt_enabled;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            burst_length     <= BL_RESET;
            column_latency   <= CL_RESET;
            additive_latency <= AL_RESET;
            odt_enabled      <= 1'b0;
            read_latency     <= 4'(CL_RESET) + 4'(AL_RESET);
            write_latency    <= 4'(CL_RESET) + 4'(AL_RESET) - 4'h1;
        end else begin
            if (cmd == CMD_MRS) begin
                burst_length   <= pins.addr[BL_HI:BL_LO];
                column_latency <= pins.addr[CL_HI:CL_LO];
            end
            if (cmd == CMD_EMRS1) begin
                additive_latency <= pins.addr[AL_HI:AL_LO];
                odt_enabled      <= pins.addr[ODT_A] | pins.addr[ODT_B];
            end
            read_latency  <= 4'(column_latency) + 4'(additive_latency);
            write_latency <= 4'(column_latency) + 4'(additive_latency) - 4'h1;
        end
    end

    // ------------------------------------------------------------
    // bank state
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bank_open <= '0;
        end else if (cmd == CMD_ACT) begin
            bank_open[bank_idx] <= 1'b1;
        end else if (cmd == CMD_PRE) begin
            if (pins.addr[AP_BIT]) begin
                bank_open <= '0;
            end else begin
                bank_open[bank_idx] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // posted column commands
    // ------------------------------------------------------------
    // one stage per link clock; the tap chosen by additive latency
    col_cmd_t col_new;
    col_cmd_t col_pipe [AL_DEPTH];

    always_comb begin
        col_new       = '0;
        col_new.valid = ((cmd == CMD_READ) || (cmd == CMD_WRITE)) && bank_open[bank_idx];
        col_new.write = (cmd == CMD_WRITE);
        col_new.bank  = bank_idx;
        col_new.col   = pins.addr;
    end

    genvar gi;
    generate
        for (gi = 0; gi < AL_DEPTH; gi++) begin : g_post
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    col_pipe[gi] <= '0;
                end else if (ck_rise) begin
                    col_pipe[gi] <= (gi == 0) ? col_new : col_pipe[(gi == 0) ? 0 : gi - 1];
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            col_launch <= '0;
        end else if (!ck_rise) begin
            col_launch <= '0;
        end else if (additive_latency == AL_RESET) begin
            col_launch <= col_new;
        end else begin
            col_launch <= col_pipe[additive_latency - 3'h1];
        end
    end

    // ------------------------------------------------------------
    // calibration mode and drive timing
    // ------------------------------------------------------------
    logic [3:0] oit_cnt;
    logic       drive_on, drive_high;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cal_mode <= MODE_OFF;
        end else if (cmd == CMD_EMRS1) begin
            case (cal_field)
                CAL_EXIT:    cal_mode <= MODE_OFF;
                CAL_HIGH:    cal_mode <= MODE_HIGH;
                CAL_LOW:     cal_mode <= MODE_LOW;
                CAL_ADJ:     cal_mode <= MODE_ADJ;
                CAL_DEFAULT: cal_mode <= MODE_DEFAULT;
                default:     cal_mode <= cal_mode;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            oit_cnt    <= 4'h0;
            drive_on   <= 1'b0;
            drive_high <= 1'b0;
        end else if (cmd == CMD_EMRS1 && (cal_field == CAL_HIGH || cal_field == CAL_LOW ||
                                          cal_field == CAL_EXIT)) begin
            oit_cnt <= OIT_CYC;
        end else if (oit_cnt != 4'h0) begin
            oit_cnt <= oit_cnt - 4'h1;
            if (oit_cnt == 4'h1) begin
                drive_on   <= (cal_mode == MODE_HIGH) || (cal_mode == MODE_LOW);
                drive_high <= (cal_mode == MODE_HIGH);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dq_out    <= '0;
            dq_oe     <= '0;
            dqs_out   <= '0;
            dqs_n_out <= '0;
            dqs_oe    <= '0;
        end else begin
            dq_out    <= {DQ_W{drive_high}};
            dqs_out   <= {DQS_W{drive_high}};
            dqs_n_out <= {DQS_W{~drive_high}};
            dq_oe     <= {DQ_W{drive_on}};
            dqs_oe    <= {DQS_W{drive_on}};
        end
    end

    // ------------------------------------------------------------
    // adjustment code capture and step counters
    // ------------------------------------------------------------
    // beats land on both link edges, so a falling-edge detect is needed
    logic       adj_wait, adj_take;
    logic [3:0] adj_cnt;
    logic [1:0] beat;
    logic [3:0] code;
    logic       apply;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            adj_wait <= 1'b0;
            adj_take <= 1'b0;
            adj_cnt  <= 4'h0;
            beat     <= 2'h0;
            code     <= 4'h0;
            apply    <= 1'b0;
        end else begin
            apply <= 1'b0;
            if (cmd == CMD_EMRS1 && cal_field == CAL_ADJ) begin
                adj_wait <= 1'b1;
                adj_take <= 1'b0;
                adj_cnt  <= write_latency;
                beat     <= 2'h0;
            end else if (adj_wait && ck_rise) begin
                if (adj_cnt <= 4'h1) begin
                    adj_wait <= 1'b0;
                    adj_take <= 1'b1;
                    code[0]  <= dq_sync[0];
                    beat     <= 2'h1;
                end else begin
                    adj_cnt <= adj_cnt - 4'h1;
                end
            end else if (adj_take && (ck_rise || ck_fall)) begin
                code[beat] <= dq_sync[0];
                beat       <= beat + 2'h1;
                if (beat == BEAT_LAST) begin
                    adj_take <= 1'b0;
                    apply    <= 1'b1;
                end
            end
        end
    end

    // one pair of counters serves every data line
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pullup_step   <= STEP_RESET;
            pulldown_step <= STEP_RESET;
        end else if (cmd == CMD_EMRS1 && cal_field == CAL_DEFAULT) begin
            pullup_step   <= STEP_RESET;
            pulldown_step <= STEP_RESET;
        end else if (apply && !(code[3] && code[2]) && !(code[1] && code[0])) begin
            if (code[3] && pullup_step != STEP_MAX) begin
                pullup_step <= pullup_step + 4'h1;
            end else if (code[2] && pullup_step != STEP_MIN) begin
                pullup_step <= pullup_step - 4'h1;
            end
            if (code[1] && pulldown_step != STEP_MAX) begin
                pulldown_step <= pulldown_step + 4'h1;
            end else if (code[0] && pulldown_step != STEP_MIN) begin
                pulldown_step <= pulldown_step - 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // termination
    // ------------------------------------------------------------
    generate
        for (gi = 0; gi < TERM_LINES; gi++) begin : g_term
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    term_en[gi] <= 1'b0;
                end else begin
                    term_en[gi] <= term_sync && odt_enabled && !sr_sync;
                end
            end
        end
    endgenerate

endmodule // ddr2_cmd_ocd_odt_core
`default_nettype wire

/* File: src/ddr2_core_pkg.sv */
`default_nettype none
package ddr2_core_pkg;

    // ------------------------------------------------------------
    // widths and clocking
    // ------------------------------------------------------------
    localparam int ADDR_W      = 13;
    localparam int DQ_W        = 16;
    localparam int DQS_W       = 2;
    localparam int BANKS       = 4;
    localparam int TERM_LINES  = DQ_W + 2 * DQS_W + 2;   // dq, dqs, dqs_n, two masks
    localparam int AL_DEPTH    = 8;
    localparam int CLK_MHZ     = 100;
    // output enable delay after an enter-drive or exit command
    localparam int OIT_NS      = 12;
    localparam int OIT_CYC_RAW = (OIT_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0] OIT_CYC = (OIT_CYC_RAW < 1) ? 4'h1 : 4'(OIT_CYC_RAW);

    // ------------------------------------------------------------
    // field positions of the mode registers
    // ------------------------------------------------------------
    localparam int AP_BIT      = 10;
    localparam int CAL_LO      = 7;
    localparam int CAL_HI      = 9;
    localparam int AL_LO       = 3;
    localparam int AL_HI       = 5;
    localparam int CL_LO       = 4;
    localparam int CL_HI       = 6;
    localparam int BL_LO       = 0;
    localparam int BL_HI       = 2;
    localparam int ODT_A       = 2;
    localparam int ODT_B       = 6;

    // ------------------------------------------------------------
    // encodings and reset values
    // ------------------------------------------------------------
    localparam logic [2:0] CAL_EXIT    = 3'h0;
    localparam logic [2:0] CAL_HIGH    = 3'h1;
    localparam logic [2:0] CAL_LOW     = 3'h2;
    localparam logic [2:0] CAL_ADJ     = 3'h4;
    localparam logic [2:0] CAL_DEFAULT = 3'h7;
    localparam logic [3:0] STEP_RESET  = 4'h8;
    localparam logic [3:0] STEP_MAX    = 4'hf;
    localparam logic [3:0] STEP_MIN    = 4'h0;
    localparam logic [1:0] BEAT_LAST   = 2'h3;
    localparam logic [2:0] BL_RESET    = 3'h2;
    localparam logic [2:0] CL_RESET    = 3'h3;
    localparam logic [2:0] AL_RESET    = 3'h0;

    typedef enum logic [2:0] {
        CMD_NONE  = 3'b000,
        CMD_ACT   = 3'b001,
        CMD_PRE   = 3'b010,
        CMD_READ  = 3'b011,
        CMD_WRITE = 3'b100,
        CMD_MRS   = 3'b101,
        CMD_EMRS1 = 3'b110,
        CMD_OTHER = 3'b111
    } cmd_t;

    typedef enum logic [2:0] {
        MODE_OFF     = 3'b000,
        MODE_HIGH    = 3'b001,
        MODE_LOW     = 3'b010,
        MODE_ADJ     = 3'b011,
        MODE_DEFAULT = 3'b100
    } cal_mode_t;

    typedef struct packed {
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic              bank_sel_hi;
        logic              bank_sel_lo;
        logic [ADDR_W-1:0] addr;
    } cmd_pins_t;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [1:0]        bank;
        logic [ADDR_W-1:0] col;
    } col_cmd_t;

endpackage
`default_nettype wire

/* File: verification/ddr2_cmd_ocd_odt_core_bench.sv */
`default_nettype none
// ----------------------------------------
// bench top
// ----------------------------------------
module ddr2_cmd_ocd_odt_core_bench
    import ddr2_core_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic                  ref_clk;
    logic                  rstn;
    logic                  termination_ctrl;
    logic                  self_refresh;
    wire logic             ck;
    wire cmd_pins_t        cmd_pins;
    wire logic [DQ_W-1:0]  dq_in;
    logic [DQ_W-1:0]       dq_out, dq_oe;
    logic [DQS_W-1:0]      dqs_out, dqs_n_out, dqs_oe;
    logic [TERM_LINES-1:0] term_en;
    cal_mode_t             cal_mode;
    logic [3:0]            pullup_step, pulldown_step, read_latency, write_latency, pu, pd, c, expb;
    logic [BANKS-1:0]      bank_open;
    col_cmd_t              col_launch, last;
    logic [2:0]            burst_length, additive_latency, al;
    logic                  lv;
    int                    failures, n_tests, rises, n_launch, at_rise, r0;
    logic [1:0]            bp [4] = '{2'b00, 2'b10, 2'b01, 2'b11};
    logic [3:0]            codes [21] = '{4'h0, 4'h8, 4'h4, 4'h2, 4'h1, 4'ha, 4'h6, 4'h9, 4'h5, 4'h9,
                                          4'h9, 4'h9, 4'h9, 4'h9, 4'h9, 4'h9, 4'h9, 4'h9, 4'hc, 4'h3, 4'hf};

    ddr2_cmd_ocd_odt_core i_dut (.ref_clk, .rstn, .ck, .cmd_pins, .termination_ctrl, .self_refresh, .dq_in,
        .dq_out, .dq_oe, .dqs_out, .dqs_n_out, .dqs_oe, .term_en, .cal_mode, .pullup_step, .pulldown_step,
        .bank_open, .col_launch, .burst_length, .additive_latency, .read_latency, .write_latency);
    ddr2_ctrl_model i_ctrl (.ref_clk, .ck, .cmd_pins, .dq_in);

    always #5 ref_clk = ~ref_clk;
    always @(posedge ck) rises++;
    always @(posedge ref_clk) begin
        if (col_launch.valid === 1'b1) begin
            n_launch++;
            last = col_launch;
            at_rise = rises;
        end
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        n_tests++;
        if (got !== want) begin
            failures++;
            $display("unexpected at %0t: got %0h want %0h", $time, got, want);
        end
    endtask
    task automatic settle;
        repeat (6) @(negedge ref_clk);
    endtask
    task automatic emrs(input logic [2:0] cal, input logic odt);
        i_ctrl.send({4'h0, 2'b01, 3'h0, cal, 1'b0, al, odt, 2'h0});
        settle();
    endtask
    function automatic logic [3:0] nxt(input logic [3:0] s, input logic up, input logic dn);
        return (up && s != 4'hf) ? s + 4'h1 : ((dn && s != 4'h0) ? s - 4'h1 : s);
    endfunction
    task automatic complete_run;
        if (failures == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge ref_clk);
        failures++;
        complete_run();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        rstn = 1'b0;
        termination_ctrl = 1'b0;
        self_refresh = 1'b0;
        al = 3'h0;
        pu = STEP_RESET;
        pd = STEP_RESET;
        repeat (6) @(negedge ref_clk);
        rstn = 1'b1;
        settle();
        chk({pullup_step, pulldown_step}, {pu, pd});
        chk({read_latency, write_latency}, 8'h32);
        chk(cal_mode, MODE_OFF);
        i_ctrl.send({4'h0, 2'b00, 6'h0, 3'h4, 1'b0, 3'h3});
        settle();
        chk(burst_length, 3'h3);
        i_ctrl.send({4'h0, 2'b00, 6'h0, 3'h4, 1'b0, 3'h2});
        settle();
        chk({burst_length, read_latency, write_latency}, {3'h2, 8'h43});
        for (int i = 0; i < 2; i++) begin
            lv = (i == 0);
            emrs(lv ? CAL_HIGH : CAL_LOW, 1'b0);
            chk(cal_mode, lv ? MODE_HIGH : MODE_LOW);
            chk({dq_out, dqs_out, dqs_n_out}, {{18{lv}}, {2{!lv}}});
            chk({dq_oe, dqs_oe}, 18'h3ffff);
            emrs(CAL_EXIT, 1'b0);
            chk({dq_oe, dqs_oe}, 18'h0);
        end
        emrs(3'h3, 1'b0);
        chk(cal_mode, MODE_OFF);
        for (int i = 0; i < 21; i++) begin
            c = codes[i];
            emrs(CAL_ADJ, 1'b0);
            i_ctrl.beats(c, {1'b0, al} + 4'h3);
            settle();
            chk(cal_mode, MODE_ADJ);
            if (!(c[3] && c[2]) && !(c[1] && c[0])) begin
                pu = nxt(pu, c[3], c[2]);
                pd = nxt(pd, c[1], c[0]);
            end
            chk({pullup_step, pulldown_step}, {pu, pd});
            emrs(CAL_EXIT, 1'b0);
        end
        emrs(CAL_DEFAULT, 1'b0);
        chk({cal_mode, pullup_step, pulldown_step}, {MODE_DEFAULT, STEP_RESET, STEP_RESET});
        emrs(CAL_EXIT, 1'b1);
        termination_ctrl = 1'b1;
        settle();
        chk(term_en, {TERM_LINES{1'b1}});
        self_refresh = 1'b1;
        settle();
        chk(term_en, 22'h0);
        self_refresh = 1'b0;
        termination_ctrl = 1'b0;
        settle();
        chk(term_en, 22'h0);
        i_ctrl.send({4'hb, 2'b00, 13'h0});
        i_ctrl.send({4'h7, 2'b00, 13'h0});
        chk(bank_open, 4'h0);
        expb = 4'h0;
        for (int i = 0; i < 4; i++) begin
            i_ctrl.send({4'h3, bp[i], 13'h0});
            expb[i] = 1'b1;
            chk(bank_open, expb);
        end
        for (int i = 0; i < 4; i++) begin
            i_ctrl.send({4'h2, bp[i], 13'h0});
            expb[i] = 1'b0;
            chk(bank_open, expb);
        end
        i_ctrl.send({4'h3, bp[2], 13'h0});
        i_ctrl.send({4'h5, bp[2], 13'h5});
        r0 = rises;
        settle();
        chk(n_launch, 32'h1);
        chk(at_rise, r0);
        chk({last.write, last.bank, last.col}, {1'b0, 2'h2, 13'h5});
        i_ctrl.send({4'h4, bp[3], 13'h7});
        settle();
        chk(n_launch, 1);
        i_ctrl.send({4'h2, 2'b00, 13'h400});
        chk(bank_open, 4'h0);
        al = 3'h2;
        emrs(CAL_EXIT, 1'b0);
        chk({additive_latency, read_latency, write_latency}, {3'h2, 8'h65});
        i_ctrl.send({4'h3, bp[0], 13'h0});
        i_ctrl.send({4'h4, bp[0], 13'h9});
        r0 = rises;
        repeat (24) @(negedge ref_clk);
        chk(n_launch, 32'h2);
        chk(at_rise, r0 + 2);
        chk({last.write, last.bank, last.col}, {1'b1, 2'h0, 13'h9});
        complete_run();
    end
endmodule // ddr2_cmd_ocd_odt_core_bench
`default_nettype wire

/* File: verification/ddr2_core_checker.sv */
`default_nettype none
// ----------------------------------------
// command, drive and termination checks
// ----------------------------------------
module ddr2_core_checker
    import ddr2_core_pkg::*;
(
    // clock, reset and controller pins
    input wire logic                  ref_clk,
    input wire logic                  rstn,
    input wire logic                  ck,
    input wire cmd_pins_t             cmd_pins,
    input wire logic                  self_refresh,
    // observed outputs
    input wire logic [DQ_W-1:0]       dq_out,
    input wire logic [DQ_W-1:0]       dq_oe,
    input wire logic [DQS_W-1:0]      dqs_out,
    input wire logic [DQS_W-1:0]      dqs_n_out,
    input wire logic [TERM_LINES-1:0] term_en,
    input wire cal_mode_t             cal_mode,
    input wire logic [3:0]            pullup_step,
    input wire logic [BANKS-1:0]      bank_open
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] cmd;
    logic [1:0] idx;
    logic [2:0] held;
    assign cmd = {cmd_pins.cs_n, cmd_pins.ras_n, cmd_pins.cas_n, cmd_pins.we_n};
    assign idx = {cmd_pins.bank_sel_lo, cmd_pins.bank_sel_hi};
    // pins change on the far clock's fall, so keep what the rise carried
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            held <= 3'h0;
        end else if ($rose(ck)) begin
            held <= {cmd_pins.addr[AP_BIT], idx};
        end
    end
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence s_cmd(logic [3:0] k);
        $rose(ck) && cmd == k;
    endsequence
    sequence s_drive_held;
        $stable(cal_mode)[*5] ##0 (cal_mode == MODE_HIGH || cal_mode == MODE_LOW);
    endsequence
    property p_drive;
        s_drive_held |-> &dq_oe && dq_out == {DQ_W{cal_mode == MODE_HIGH}}
            && dqs_out == {DQS_W{cal_mode == MODE_HIGH}} && dqs_n_out == {DQS_W{cal_mode == MODE_LOW}};
    endproperty
    a_drive: assert property (p_drive) else $error("drive levels wrong");
    property p_off;
        (cal_mode == MODE_OFF)[*5] |-> dq_oe == '0;
    endproperty
    a_off: assert property (p_off) else $error("drivers left on");
    property p_step;
        $changed(pullup_step) |-> pullup_step == STEP_RESET
            || {1'b0, pullup_step} == {1'b0, $past(pullup_step)} + 5'h1
            || {1'b0, $past(pullup_step)} == {1'b0, pullup_step} + 5'h1;
    endproperty
    a_step: assert property (p_step) else $error("step jumped");
    property p_term_sr;
        self_refresh[*6] |-> term_en == '0;
    endproperty
    a_term_sr: assert property (p_term_sr) else $error("termination on in self refresh");
    property p_act;
        s_cmd(4'h3) |-> ##[2:6] bank_open[held[1:0]];
    endproperty
    a_act: assert property (p_act) else $error("bank not opened");
    property p_pre;
        s_cmd(4'h2) |-> ##[2:6] (held[2] ? bank_open == '0 : !bank_open[held[1:0]]);
    endproperty
    a_pre: assert property (p_pre) else $error("bank not closed");
    property p_desel;
        $rose(ck) && cmd[3] |-> ##1 $stable(bank_open)[*6];
    endproperty
    a_desel: assert property (p_desel) else $error("deselect changed banks");
    property p_adj;
        s_cmd(4'h0) ##0 (idx == 2'b10 && cmd_pins.addr[CAL_HI:CAL_LO] == CAL_ADJ) |-> ##[2:6] cal_mode == MODE_ADJ;
    endproperty
    a_adj: assert property (p_adj) else $error("adjust mode missed");
endmodule // ddr2_core_checker

bind ddr2_cmd_ocd_odt_core ddr2_core_checker i_chk (
    .ref_clk, .rstn, .ck, .cmd_pins, .self_refresh, .dq_out, .dq_oe, .dqs_out,
    .dqs_n_out, .term_en, .cal_mode, .pullup_step, .bank_open
);
`default_nettype wire

/* File: verification/ddr2_ctrl_model.sv */
`default_nettype none
// ----------------------------------------
// controller side of the command link
// ----------------------------------------
module ddr2_ctrl_model
    import ddr2_core_pkg::*;
(
    // system clock, only for aligning pin changes
    input  wire logic            ref_clk,
    // link clock, commands and data
    output var logic             ck,
    output var cmd_pins_t        cmd_pins,
    output var logic [DQ_W-1:0]  dq_in
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        ck = 1'b0;
        cmd_pins = {1'b1, 18'h0};
        dq_in = '0;
        #3;
        forever #40 ck = ~ck;
    end
    // one command, then a deselect that scrambles the rest of the pins;
    // two link clocks per command keep every spacing rule trivially
    task automatic send(input logic [18:0] v);
        @(negedge ck);
        @(negedge ref_clk);
        cmd_pins = v;
        @(negedge ck);
        @(negedge ref_clk);
        cmd_pins = {1'b1, ~v[17:0]};
    endtask
    // call right after send; beats land centred on write-latency edges
    task automatic beats(input logic [3:0] code, input logic [3:0] wl);
        repeat (wl - 4'h1) @(negedge ck);
        for (int i = 0; i < 4; i++) begin
            #20;
            @(negedge ref_clk);
            dq_in = {DQ_W{code[i]}};
            @(ck);
        end
        #20;
        dq_in = ~dq_in;
    endtask
endmodule // ddr2_ctrl_model
`default_nettype wire
